// ---- design/dpp_pkg.sv ----
// Shared constants, formats and carrier types of the display pixel pipeline.
package dpp_pkg;

    // Register byte addresses on the APB slave.
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_ZOOM = 8'h04;
    localparam logic [7:0] A_WINX = 8'h08;
    localparam logic [7:0] A_WINY = 8'h0C;
    localparam logic [7:0] A_CKEY = 8'h10;
    localparam logic [7:0] A_VKEY = 8'h14;
    localparam logic [7:0] A_PIDX = 8'h18;
    localparam logic [7:0] A_PDAT = 8'h1C;
    localparam logic [7:0] A_STAT = 8'h20;

    // Field positions inside the registers.
    localparam int CTRL_W  = 11;
    localparam int ZH_LSB  = 0;
    localparam int ZV_LSB  = 4;
    localparam int WEND    = 16;
    localparam int ST_LVG  = 4;
    localparam int ST_LVV  = 12;

    // Stream widths and sizes.
    localparam int DW    = 32;
    localparam int DEPTH = 8;
    localparam int BURST = 4;
    localparam int CW    = 12;
    localparam int PALN  = 256;
    localparam int PALW  = 18;

    // Zoom limits and the interpolation weight unit (sixteenths).
    localparam logic [2:0] ZOOM_MIN = 3'h1;
    localparam logic [2:0] ZOOM_MAX = 3'h4;
    localparam logic [2:0] VI_MIN   = 3'h2;
    localparam int         WSH      = 4;

    // Pixel formats, shared by the graphics and video streams.
    typedef enum logic [2:0] {
        F_IDX8   = 3'h0,
        F_RGB332 = 3'h1,
        F_RGB555 = 3'h2,
        F_RGB565 = 3'h3,
        F_RGB888 = 3'h4,
        F_YUV422 = 3'h5,
        F_YUVC   = 3'h6
    } fmt_t;

    // Control register layout, most significant field first.
    typedef struct packed {
        fmt_t vid_fmt;
        fmt_t gfx_fmt;
        logic pwr_down;
        logic vinterp;
        logic key_sel;
        logic occl_en;
        logic win_en;
    } ctrl_t;

    // One output colour, eight bits per gun.
    typedef struct packed {
        logic [7:0] r;
        logic [7:0] g;
        logic [7:0] b;
    } rgb_t;

    // Weight step per output pixel for a zoom factor, in sixteenths.
    function automatic logic [4:0] zstep(input logic [2:0] z);
        case (z)
            3'h2:    zstep = 5'h08;
            3'h3:    zstep = 5'h05;
            3'h4:    zstep = 5'h04;
            default: zstep = 5'h10;
        endcase
    endfunction : zstep

endpackage : dpp_pkg

// ---- design/dpp_top.sv ----
// Display pixel pipeline: two display FIFOs, video window, palette, APB.
`timescale 1ns/1ps

module pix_fifo #(
    parameter int W = 32,
    parameter int D = 8
) (
    input  wire logic           clk,
    input  wire logic           rst_n,
    input  wire logic           in_valid,
    output logic                in_ready,
    input  wire logic [W-1:0]   in_data,
    output logic                out_valid,
    input  wire logic           out_ready,
    output logic [W-1:0]        out_data,
    output logic [$clog2(D):0]  level
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
    } fst_t;

    fst_t st_ff;
    fst_t nxt_st;
    logic push;
    logic pop;

    // Ready and valid are honest: full stalls the filler, empty the reader.
    assign in_ready  = st_ff.cnt != (AW+1)'(D);
    assign out_valid = st_ff.cnt != '0;
    assign out_data  = st_ff.mem[st_ff.rp];
    assign level     = st_ff.cnt;
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Pointer and count update; wrap relies on D being a power of two.
    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.mem[st_ff.wp] = in_data;
            nxt_st.wp = st_ff.wp + 1'b1;
        end
        if (pop) begin
            nxt_st.rp = st_ff.rp + 1'b1;
        end
        nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule : pix_fifo

module dpp_top (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                gfx_wr_valid,
    output logic                     gfx_wr_ready,
    input  wire logic [31:0]         gfx_wr_data,
    input  wire logic                vid_wr_valid,
    output logic                     vid_wr_ready,
    input  wire logic [31:0]         vid_wr_data,
    output logic                     gfx_fetch_req,
    output logic                     vid_fetch_req,
    input  wire logic                disp_active,
    input  wire logic                line_start,
    input  wire logic [11:0]         disp_x,
    input  wire logic [11:0]         disp_y,
    output logic                     pix_valid,
    output dpp_pkg::rgb_t            pix_rgb,
    output logic                     vid_line_next,
    output logic                     dac_pwr_en
);
    localparam int LW = $clog2(dpp_pkg::DEPTH) + 1;

    typedef struct packed {
        dpp_pkg::ctrl_t                   ctrl;
        logic [2:0]                       hz;
        logic [2:0]                       vz;
        logic [11:0]                      wx0;
        logic [11:0]                      wx1;
        logic [11:0]                      wy0;
        logic [11:0]                      wy1;
        logic [15:0]                      ckey;
        logic [23:0]                      vkey;
        logic [7:0]                       pidx;
        logic [255:0][17:0]               pal;
        logic [31:0]                      prdata;
        logic                             gund;
        logic                             vund;
        logic [2:0]                       hph;
        logic [2:0]                       vph;
        dpp_pkg::rgb_t                    cur;
        dpp_pkg::rgb_t                    cur2;
        dpp_pkg::rgb_t                    rgb;
        logic                             pvalid;
        logic                             vnext;
    } st_t;

    st_t            st_ff;
    st_t            nxt_st;
    logic           g_valid, g_pop, v_valid, v_pop;
    logic [31:0]    g_head, v_head;
    logic [LW-1:0]  g_lvl, v_lvl;
    logic           setup, wr, mapped;
    logic [31:0]    rd_val;
    logic           in_win, y_win, vint, occl_ok, show_vid;
    logic           g8, gkey_hit, vkey_hit;
    logic [2:0]     hzc, vzc;
    dpp_pkg::rgb_t  g_rgb, vh, vbh, va, vb, vid_pix;

    // Clamp a programmed zoom factor into the supported one to four.
    function automatic logic [2:0] zclamp(input logic [2:0] z);
        if (z < dpp_pkg::ZOOM_MIN) begin
            zclamp = dpp_pkg::ZOOM_MIN;
        end else if (z > dpp_pkg::ZOOM_MAX) begin
            zclamp = dpp_pkg::ZOOM_MAX;
        end else begin
            zclamp = z;
        end
    endfunction : zclamp

    // Saturate a signed intermediate to one 8-bit gun.
    function automatic logic [7:0] sat8(input int x);
        if (x < 0) begin
            sat8 = 8'h00;
        end else if (x > 255) begin
            sat8 = 8'hFF;
        end else begin
            sat8 = 8'(x);
        end
    endfunction : sat8

    // Blend two colours with a weight in sixteenths toward the second.
    function automatic dpp_pkg::rgb_t lerp(input dpp_pkg::rgb_t a,
                                           input dpp_pkg::rgb_t b,
                                           input logic [4:0] w);
        lerp.r = sat8(int'(a.r) + (((int'(b.r) - int'(a.r)) * int'(w))
                                   >>> dpp_pkg::WSH));
        lerp.g = sat8(int'(a.g) + (((int'(b.g) - int'(a.g)) * int'(w))
                                   >>> dpp_pkg::WSH));
        lerp.b = sat8(int'(a.b) + (((int'(b.b) - int'(a.b)) * int'(w))
                                   >>> dpp_pkg::WSH));
    endfunction : lerp

    // Integer YUV to RGB; shift sums keep it free of multipliers.
    function automatic dpp_pkg::rgb_t yuv(input logic [7:0] y,
                                          input logic [7:0] u,
                                          input logic [7:0] v);
        int uu;
        int vv;
        uu = int'(u) - 128;
        vv = int'(v) - 128;
        yuv.r = sat8(int'(y) + vv + (vv >>> 2) + (vv >>> 3));
        yuv.g = sat8(int'(y) - (uu >>> 2) - (vv >>> 1) - (vv >>> 3));
        yuv.b = sat8(int'(y) + uu + (uu >>> 1) + (uu >>> 2));
    endfunction : yuv

    // Format conversion to 24-bit colour; the palette serves indexed data.
    function automatic dpp_pkg::rgb_t conv(input dpp_pkg::fmt_t f,
                                           input logic [31:0] d,
                                           input logic [17:0] pe);
        case (f)
            dpp_pkg::F_IDX8:   conv = {pe[17:12], 2'h0, pe[11:6], 2'h0,
                                       pe[5:0], 2'h0};
            dpp_pkg::F_RGB332: conv = {d[7:5], 5'h00, d[4:2], 5'h00,
                                       d[1:0], 6'h00};
            dpp_pkg::F_RGB555: conv = {d[14:10], 3'h0, d[9:5], 3'h0,
                                       d[4:0], 3'h0};
            dpp_pkg::F_RGB565: conv = {d[15:11], 3'h0, d[10:5], 2'h0,
                                       d[4:0], 3'h0};
            dpp_pkg::F_YUV422: conv = yuv(d[7:0], d[15:8], d[23:16]);
            dpp_pkg::F_YUVC:   conv = yuv({d[15:10], 2'h0}, {d[9:5], 3'h0},
                                          {d[4:0], 3'h0});
            default:           conv = d[23:0];
        endcase
    endfunction : conv

    pix_fifo #(.W(dpp_pkg::DW), .D(dpp_pkg::DEPTH)) gfx_fifo (
        .clk       (pclk),
        .rst_n     (presetn),
        .in_valid  (gfx_wr_valid),
        .in_ready  (gfx_wr_ready),
        .in_data   (gfx_wr_data),
        .out_valid (g_valid),
        .out_ready (g_pop),
        .out_data  (g_head),
        .level     (g_lvl)
    );

    pix_fifo #(.W(dpp_pkg::DW), .D(dpp_pkg::DEPTH)) vid_fifo (
        .clk       (pclk),
        .rst_n     (presetn),
        .in_valid  (vid_wr_valid),
        .in_ready  (vid_wr_ready),
        .in_data   (vid_wr_data),
        .out_valid (v_valid),
        .out_ready (v_pop),
        .out_data  (v_head),
        .level     (v_lvl)
    );

    // prefetch request: room for a whole page-mode burst.
    assign gfx_fetch_req = g_lvl <= LW'(dpp_pkg::DEPTH - dpp_pkg::BURST);
    assign vid_fetch_req = v_lvl <= LW'(dpp_pkg::DEPTH - dpp_pkg::BURST);

    // APB decode; every access completes without wait states.
    assign setup  = psel & ~penable;
    assign wr     = psel & penable & pwrite;
    assign mapped = paddr <= dpp_pkg::A_STAT && paddr[1:0] == 2'h0;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata = st_ff.prdata;

    // Read mux; the table reads as zero while power-down is set.
    always_comb begin
        rd_val = 32'h0;
        case (paddr)
            dpp_pkg::A_CTRL: rd_val[dpp_pkg::CTRL_W-1:0] = st_ff.ctrl;
            dpp_pkg::A_ZOOM: rd_val = {25'h0, st_ff.vz, 1'b0, st_ff.hz};
            dpp_pkg::A_WINX: rd_val = {4'h0, st_ff.wx1, 4'h0, st_ff.wx0};
            dpp_pkg::A_WINY: rd_val = {4'h0, st_ff.wy1, 4'h0, st_ff.wy0};
            dpp_pkg::A_CKEY: rd_val[15:0] = st_ff.ckey;
            dpp_pkg::A_VKEY: rd_val[23:0] = st_ff.vkey;
            dpp_pkg::A_PIDX: rd_val[7:0] = st_ff.pidx;
            dpp_pkg::A_PDAT: begin
                if (!st_ff.ctrl.pwr_down) begin
                    rd_val[17:0] = st_ff.pal[st_ff.pidx];
                end
            end
            dpp_pkg::A_STAT: rd_val = {20'h0, v_lvl, g_lvl,
                                       (st_ff.ctrl.occl_en & ~occl_ok),
                                       st_ff.ctrl.occl_en & st_ff.ctrl.vinterp,
                                       st_ff.vund, st_ff.gund};
            default:         rd_val = 32'h0;
        endcase
    end

    // Window geometry and effective zoom factors.
    assign hzc    = zclamp(st_ff.hz);
    assign vzc    = zclamp(st_ff.vz);
    assign y_win  = disp_y >= st_ff.wy0 && disp_y <= st_ff.wy1;
    assign in_win = st_ff.ctrl.win_en & y_win
                  & disp_x >= st_ff.wx0 & disp_x <= st_ff.wx1;
    // occlusion only with 8 or 16 bits per graphics pixel
    assign g8 = st_ff.ctrl.gfx_fmt == dpp_pkg::F_IDX8
              | st_ff.ctrl.gfx_fmt == dpp_pkg::F_RGB332;
    assign occl_ok = st_ff.ctrl.occl_en & (g8
                   | st_ff.ctrl.gfx_fmt == dpp_pkg::F_RGB555
                   | st_ff.ctrl.gfx_fmt == dpp_pkg::F_RGB565);
    // line blending needs a factor of two or more and the second FIFO free
    assign vint = st_ff.ctrl.vinterp & ~st_ff.ctrl.occl_en
                & vzc >= dpp_pkg::VI_MIN;

    // the second FIFO feeds the next video line when blending.
    assign g_pop = disp_active & ~(in_win & vint) & g_valid;
    assign v_pop = disp_active & in_win & st_ff.hph == 3'h0 & v_valid;

    // graphics format, with table lookup for indexed data.
    assign g_rgb = conv(st_ff.ctrl.gfx_fmt, g_head, st_ff.pal[g_head[7:0]]);
    // video format is chosen apart from graphics.
    assign vh    = conv(st_ff.ctrl.vid_fmt, v_head, st_ff.pal[v_head[7:0]]);
    assign vbh   = conv(st_ff.ctrl.vid_fmt, g_head, st_ff.pal[g_head[7:0]]);

    // horizontal zoom blends the held pixel toward the next one.
    assign va = lerp(st_ff.hph == 3'h0 ? vh : st_ff.cur,
                     v_valid ? vh : st_ff.cur,
                     5'(st_ff.hph * dpp_pkg::zstep(hzc)));
    assign vb = lerp(st_ff.hph == 3'h0 ? vbh : st_ff.cur2,
                     g_valid ? vbh : st_ff.cur2,
                     5'(st_ff.hph * dpp_pkg::zstep(hzc)));
    // vertical blend between the two lines, else plain repetition.
    assign vid_pix = vint ? lerp(va, vb, 5'(st_ff.vph * dpp_pkg::zstep(vzc)))
                          : va;

    // colour key on graphics or chroma key on video.
    assign gkey_hit = g8 ? g_head[7:0] == st_ff.ckey[7:0]
                         : g_head[15:0] == st_ff.ckey;
    assign vkey_hit = v_head[23:0] == st_ff.vkey;
    assign show_vid = in_win & (~occl_ok
                    | (st_ff.ctrl.key_sel ? ~vkey_hit : gkey_hit));

    // converters are powered only outside power-down.
    assign dac_pwr_en    = ~st_ff.ctrl.pwr_down;
    assign pix_valid     = st_ff.pvalid;
    assign pix_rgb       = st_ff.rgb;
    assign vid_line_next = st_ff.vnext;

    // Next-state: registers, zoom phases, sticky status, output stage.
    always_comb begin
        nxt_st = st_ff;
        nxt_st.vnext = 1'b0;
        if (setup) begin
            nxt_st.prdata = rd_val;
        end
        if (wr) begin
            case (paddr)
                dpp_pkg::A_CTRL: nxt_st.ctrl = pwdata[dpp_pkg::CTRL_W-1:0];
                dpp_pkg::A_ZOOM: begin
                    nxt_st.hz = pwdata[dpp_pkg::ZH_LSB +: 3];
                    nxt_st.vz = pwdata[dpp_pkg::ZV_LSB +: 3];
                end
                dpp_pkg::A_WINX: begin
                    nxt_st.wx0 = pwdata[11:0];
                    nxt_st.wx1 = pwdata[dpp_pkg::WEND +: dpp_pkg::CW];
                end
                dpp_pkg::A_WINY: begin
                    nxt_st.wy0 = pwdata[11:0];
                    nxt_st.wy1 = pwdata[dpp_pkg::WEND +: dpp_pkg::CW];
                end
                dpp_pkg::A_CKEY: nxt_st.ckey = pwdata[15:0];
                dpp_pkg::A_VKEY: nxt_st.vkey = pwdata[23:0];
                dpp_pkg::A_PIDX: nxt_st.pidx = pwdata[7:0];
                dpp_pkg::A_PDAT: begin
                    if (!st_ff.ctrl.pwr_down) begin
                        nxt_st.pal[st_ff.pidx] = pwdata[17:0];
                        nxt_st.pidx = st_ff.pidx + 8'h01;
                    end
                end
                default: ;
            endcase
        end
        // Write-one clears; an underflow in the same cycle still sets.
        if (wr && paddr == dpp_pkg::A_STAT) begin
            nxt_st.gund = st_ff.gund & ~pwdata[0];
            nxt_st.vund = st_ff.vund & ~pwdata[1];
        end
        if (disp_active & ~(in_win & vint) & ~g_valid) begin
            nxt_st.gund = 1'b1;
        end
        if (disp_active & in_win & st_ff.hph == 3'h0
            & (~v_valid | (vint & ~g_valid))) begin
            nxt_st.vund = 1'b1;
        end
        // horizontal phase runs across each zoomed source pixel.
        if (disp_active) begin
            if (in_win && st_ff.hph != hzc - 3'h1) begin
                nxt_st.hph = st_ff.hph + 3'h1;
            end else begin
                nxt_st.hph = 3'h0;
            end
        end
        if (v_pop) begin
            nxt_st.cur = vh;
        end
        if (v_pop & vint & g_valid) begin
            nxt_st.cur2 = vbh;
        end
        // a source line repeats until the vertical phase wraps.
        if (line_start) begin
            if (!st_ff.ctrl.win_en || !y_win || st_ff.vph == vzc - 3'h1) begin
                nxt_st.vph = 3'h0;
                nxt_st.vnext = st_ff.ctrl.win_en & y_win;
            end else begin
                nxt_st.vph = st_ff.vph + 3'h1;
            end
        end
        // blank output while the converters are off.
        nxt_st.pvalid = disp_active;
        if (st_ff.ctrl.pwr_down || !disp_active) begin
            nxt_st.rgb = '0;
        end else begin
            nxt_st.rgb = show_vid ? vid_pix : g_rgb;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);

    fetch_level_a: assert property (
        (g_lvl == LW'(dpp_pkg::DEPTH)) |-> !gfx_fetch_req
    ) else $error("fetch requested with a full graphics FIFO");

    zoom_phase_a: assert property (
        disp_active && in_win |-> st_ff.hph < hzc
    ) else $error("horizontal phase beyond zoom factor");

    hold_pix_a: assert property (
        disp_active && in_win && st_ff.hph != 3'h0 |-> !v_pop
    ) else $error("video popped inside an interpolated run");

    vblend_ok_a: assert property (
        vint |-> vzc >= dpp_pkg::VI_MIN && !st_ff.ctrl.occl_en
    ) else $error("line blending at factor one or with occlusion");

    sequence gfx_keyed_s;
        disp_active && occl_ok && !st_ff.ctrl.key_sel && in_win
        && gkey_hit && g_valid && v_valid && !st_ff.ctrl.pwr_down;
    endsequence
    key_replace_a: assert property (
        gfx_keyed_s |=> pix_rgb == $past(vid_pix)
    ) else $error("colour key hit did not show video");

    occl_bpp_a: assert property (
        st_ff.ctrl.gfx_fmt == dpp_pkg::F_RGB888 |-> !occl_ok
    ) else $error("occlusion enabled at 24 bits per pixel");

    fifo_excl_a: assert property (
        st_ff.ctrl.occl_en |-> !vint
    ) else $error("occlusion and line blending both active");

    pal_lookup_a: assert property (
        disp_active && !in_win && !st_ff.ctrl.pwr_down && g_valid
        && st_ff.ctrl.gfx_fmt == dpp_pkg::F_IDX8
        |=> pix_rgb == {$past(st_ff.pal[g_head[7:0]][17:12]), 2'h0,
                        $past(st_ff.pal[g_head[7:0]][11:6]), 2'h0,
                        $past(st_ff.pal[g_head[7:0]][5:0]), 2'h0}
    ) else $error("indexed pixel not taken from the table");

    // The converter enable follows the mode at once; the output and the
    // table are judged one cycle on, so leaving power-down is not a fault.
    sleep_a: assert property (
        st_ff.ctrl.pwr_down |-> !dac_pwr_en
                                ##1 (pix_rgb == '0 && $stable(st_ff.pal))
    ) else $error("output or table active during power-down");

    pass_gfx_a: assert property (
        disp_active && !st_ff.ctrl.win_en && !st_ff.ctrl.pwr_down
        |=> pix_rgb == $past(g_rgb) ##0 $past(g_pop) == $past(g_valid)
    ) else $error("graphics not passed with the window off");

endmodule : dpp_top

// ---- tb/arb_model.sv ----
// Memory arbiter model that fills one display FIFO in bursts.
`timescale 1ns/1ps
module arb_model #(
    parameter logic [15:0] BASE = 16'h0000
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        fetch_req,
    input  wire logic        stall,
    output logic             wr_valid,
    input  wire logic        wr_ready,
    output logic [31:0]      wr_data
);
    logic [2:0] left_ff;
    logic [7:0] n_ff;
    logic [31:0] word;
    // burst on request: a started burst finishes even when stalled.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left_ff <= 3'h0;
            n_ff    <= 8'h00;
        end else if (wr_valid && wr_ready) begin
            left_ff <= left_ff - 3'h1;
            n_ff    <= n_ff + 8'h01;
        end else if (left_ff == 3'h0 && fetch_req && !stall) begin
            left_ff <= 3'(dpp_pkg::BURST);
        end
    end
    // Idle data is inverted so a stale word can never pass for a new one.
    assign word     = {8'h00, BASE, n_ff};
    assign wr_valid = (left_ff != 3'h0);
    assign wr_data  = wr_valid ? word : ~word;
endmodule : arb_model

// ---- tb/display_pixel_pipeline_test.sv ----
// Self-checking bench for the display pixel pipeline.
`timescale 1ns/1ps
module display_pixel_pipeline_test;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, stall;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, gfx_wr_data, vid_wr_data;
    logic gfx_wr_valid, gfx_wr_ready, vid_wr_valid, vid_wr_ready;
    logic gfx_fetch_req, vid_fetch_req, disp_active, line_start;
    logic pix_valid, vid_line_next, dac_pwr_en;
    logic [11:0] disp_x, disp_y;
    dpp_pkg::rgb_t pix_rgb;
    int failures, compares, gpop;
    dpp_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .gfx_wr_valid, .gfx_wr_ready,
        .gfx_wr_data, .vid_wr_valid, .vid_wr_ready, .vid_wr_data,
        .gfx_fetch_req, .vid_fetch_req, .disp_active, .line_start, .disp_x,
        .disp_y, .pix_valid, .pix_rgb, .vid_line_next, .dac_pwr_en);
    // two independent fill streams, one model for each.
    arb_model #(.BASE(16'hC396)) gfx_u (.pclk, .presetn, .stall,
        .fetch_req(gfx_fetch_req), .wr_valid(gfx_wr_valid),
        .wr_ready(gfx_wr_ready), .wr_data(gfx_wr_data));
    arb_model #(.BASE(16'h5A21)) vid_u (.pclk, .presetn, .stall,
        .fetch_req(vid_fetch_req), .wr_valid(vid_wr_valid),
        .wr_ready(vid_wr_ready), .wr_data(vid_wr_data));
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    // One APB transfer; waits up to 50 cycles for pready, else counts a failure.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk); psel <= 1'b1; penable <= 1'b0;
        pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk); penable <= 1'b1;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) failures++;
        rd = prdata; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    // One active pixel; the colour shows one cycle later, under a mask.
    task automatic pixel(input logic [31:0] e, input logic [31:0] m);
        @(posedge pclk); disp_active <= 1'b1;
        @(posedge pclk); disp_active <= 1'b0;
        #1 gpop++;
        chk("pix_valid", 32'h1, {31'h0, pix_valid});
        chk("pix_rgb", e, {8'h00, pix_rgb} & m);
    endtask : pixel
    task automatic t_reset;
        repeat (30) @(posedge pclk);
        chk("dac_pwr_en", 32'h1, {31'h0, dac_pwr_en});
        chk("gfx_wr_ready", 32'h0, {31'h0, gfx_wr_ready});
        apb(1'b0, dpp_pkg::A_STAT, 32'h0);
        chk("levels", 32'h88, {24'h0, rd[11:4]});
        apb(1'b0, 8'h24, 32'h0);
        chk("pslverr", 32'h1, {31'h0, err});
        chk("unmapped", 32'h0, rd);
    endtask : t_reset
    task automatic t_colour;
        apb(1'b1, dpp_pkg::A_CTRL, 32'h80);
        pixel({8'h00, 16'hC396, 8'(gpop)}, 32'hFFFFFF);
        apb(1'b1, dpp_pkg::A_CTRL, 32'h0);
        apb(1'b1, dpp_pkg::A_PIDX, {24'h0, 8'(gpop)});
        apb(1'b1, dpp_pkg::A_PDAT, 32'h3F015);
        pixel(32'hFC0054, 32'hFCFCFC);
        apb(1'b1, dpp_pkg::A_CTRL, 32'h8A);
        apb(1'b0, dpp_pkg::A_STAT, 32'h0);
        chk("excl", 32'h1, {31'h0, rd[2]});
        chk("bpp_off", 32'h1, {31'h0, rd[3]});
        apb(1'b1, dpp_pkg::A_CTRL, 32'h62);
        apb(1'b0, dpp_pkg::A_STAT, 32'h0);
        chk("bpp_on", 32'h0, {31'h0, rd[3]});
    endtask : t_colour
    task automatic t_power;
        apb(1'b1, dpp_pkg::A_CTRL, 32'h90);
        #1 chk("dac_off", 32'h0, {31'h0, dac_pwr_en});
        pixel(32'h0, 32'hFFFFFF);
        apb(1'b0, dpp_pkg::A_PDAT, 32'h0);
        chk("pal_read", 32'h0, rd);
    endtask : t_power
    // Drain with the arbiter stalled, then clear the sticky underflow.
    task automatic t_drain;
        apb(1'b1, dpp_pkg::A_CTRL, 32'h0);
        stall <= 1'b1;
        repeat (10) @(posedge pclk);
        repeat (10) pixel(32'h0, 32'hFFFFFF);
        chk("fetch_req", 32'h1, {31'h0, gfx_fetch_req});
        apb(1'b0, dpp_pkg::A_STAT, 32'h0);
        chk("underflow", 32'h1, {31'h0, rd[0]});
        apb(1'b1, dpp_pkg::A_STAT, 32'h1);
        apb(1'b0, dpp_pkg::A_STAT, 32'h0);
        chk("uf_clear", 32'h0, {31'h0, rd[0]});
    endtask : t_drain
    // Window at the origin: video shown, keyed, zoomed, then in YUV.
    task automatic t_window;
        stall <= 1'b0;
        repeat (10) @(posedge pclk);
        apb(1'b1, dpp_pkg::A_CKEY, 32'h9);
        apb(1'b1, dpp_pkg::A_CTRL, 32'h201);
        pixel(32'h404000, 32'hFFFFFF);
        apb(1'b1, dpp_pkg::A_CTRL, 32'h203);
        pixel(32'h404008, 32'hFFFFFF);
        pixel(32'h0, 32'hFFFFFF);
        apb(1'b1, dpp_pkg::A_CTRL, 32'h201);
        apb(1'b1, dpp_pkg::A_ZOOM, 32'h2);
        pixel(32'h404018, 32'hFFFFFF);
        pixel(32'h40401C, 32'hFFFFFF);
        apb(1'b1, dpp_pkg::A_CTRL, 32'h501);
        pixel(32'h3400, 32'hFFFFFF);
        line_start <= 1'b1;
        @(posedge pclk);
        line_start <= 1'b0;
        #1 chk("line_next", 32'h1, {31'h0, vid_line_next});
    endtask : t_window
    task automatic complete_run;
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; stall = 1'b0; disp_active = 1'b0;
        line_start = 1'b0; disp_x = 12'h000; disp_y = 12'h000;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset; t_colour; t_power; t_drain; t_window;
        complete_run;
    end
    // Watchdog: the whole sequence needs well under two thousand cycles.
    initial begin
        #40000;
        failures++;
        complete_run;
    end
endmodule : display_pixel_pipeline_test
